// File: src/ddr2_mr_pkg.sv
// Package with register map, field layout, reset values and types for the control block.
package ddr2_mr_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_PAD_URG = 12'h04C;
  localparam logic [ADDR_W-1:0] OFS_STATE = 12'h050;
  localparam logic [ADDR_W-1:0] OFS_MR_CTRL = 12'h054;
  localparam int POS_PAD_DIS = 12;
  localparam int POS_PAD_TIME = 8;
  localparam int POS_HYST = 0;
  localparam int POS_OPSTATE = 28;
  localparam int POS_HPR_FILL = 20;
  localparam int POS_LPR_FILL = 12;
  localparam int POS_WR_FILL = 4;
  localparam int POS_STALL = 0;
  localparam int POS_MR_BUSY = 31;
  localparam int POS_MR_SEL = 20;
  localparam int POS_MR_STROBE = 16;
  localparam int POS_MR_VALUE = 0;
  localparam logic RST_PAD_DIS = 1'b0;
  localparam logic [2:0] RST_PAD_TIME = 3'h7;
  localparam logic [7:0] RST_HYST = 8'h00;
  localparam logic [1:0] RST_MR_SEL = 2'h0;
  localparam logic [15:0] RST_MR_VALUE = 16'h0000;
  localparam logic [1:0] OPST_UNINIT = 2'h0;
  localparam logic [1:0] OPST_NORMAL = 2'h1;
  localparam logic [1:0] OPST_POWERDOWN = 2'h2;
  localparam logic [1:0] OPST_SELF_REFRESH = 2'h3;
  typedef enum logic [2:0] {
    MR_IDLE = 3'b001,
    MR_WRITE = 3'b010,
    MR_READ = 3'b100
  } mr_state_t;
  typedef struct packed {
    logic [3:0] high_prio_read_queue_fill;
    logic [3:0] low_prio_read_queue_fill;
    logic [3:0] write_queue_fill;
    logic controller_stalled;
  } queue_status_t;
  typedef struct packed {
    logic valid;
    logic [1:0] bank;
    logic [15:0] addr;
  } mr_cmd_t;
endpackage

// File: src/ddr2_ctrl_status_mode_reg_access.sv
// Control, status and mode-register access block of the DDR2 controller with an APB slave.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module ddr2_ctrl_status_mode_reg_access #(
  parameter int FILL_W = 4,
  parameter int HYST_W = 8
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic SOFT_RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ddr2_mr_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic INIT_DONE,
  input wire logic DRAM_POWERDOWN,
  input wire logic DRAM_SELF_REFRESH,
  input wire ddr2_mr_pkg::queue_status_t QUEUE_STATUS,
  input wire logic READ_QUEUE_URGENT_REQUEST,
  input wire logic WRITE_QUEUE_URGENT_REQUEST,
  output logic READ_QUEUE_CRITICAL,
  output logic WRITE_QUEUE_CRITICAL,
  output logic PAD_POWERDOWN_ENABLE,
  output logic [2:0] PAD_POWERDOWN_TIME,
  input wire logic MR_READ_REQ,
  input wire logic MR_READ_DONE,
  input wire logic DRAM_CMD_IDLE,
  output ddr2_mr_pkg::mr_cmd_t MR_CMD,
  output logic MODE_REG_ACCESS_BUSY
);
  import ddr2_mr_pkg::*;

  logic pad_powerdown_disable;
  logic [2:0] pad_powerdown_time;
  logic [HYST_W-1:0] critical_entry_hysteresis;
  logic [1:0] mode_reg_select;
  logic [15:0] mode_reg_write_value;
  logic mode_reg_write_strobe;
  logic [1:0] controller_operating_state;
  queue_status_t qstat;
  mr_state_t mr_state;
  mr_state_t next_mr_state;
  logic [HYST_W-1:0] rd_urgent_cnt;
  logic [HYST_W-1:0] wr_urgent_cnt;
  logic wr_access;
  logic rd_access;
  logic addr_hit;
  logic accept_write;
  logic accept_read;
  logic cmd_issued;
  logic soft_clear;

  function automatic logic [HYST_W-1:0] sat_inc(input logic [HYST_W-1:0] v);
    sat_inc = (v == '1) ? v : v + 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped addresses.

  assign addr_hit = (PADDR == OFS_PAD_URG) || (PADDR == OFS_STATE) || (PADDR == OFS_MR_CTRL);
  assign wr_access = PSEL && PENABLE && PWRITE;
  assign rd_access = PSEL && !PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_hit;
  assign soft_clear = !RST_B || !SOFT_RST_B;

  // Pad fields are reset only by the power-on reset, so a soft reset keeps them.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      pad_powerdown_disable <= RST_PAD_DIS;
      pad_powerdown_time <= RST_PAD_TIME;
    end else if (wr_access && PADDR == OFS_PAD_URG) begin
      pad_powerdown_disable <= PWDATA[POS_PAD_DIS];
      pad_powerdown_time <= PWDATA[POS_PAD_TIME +: 3];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (soft_clear) begin
      critical_entry_hysteresis <= RST_HYST;
    end else if (wr_access && PADDR == OFS_PAD_URG) begin
      critical_entry_hysteresis <= PWDATA[POS_HYST +: HYST_W];
    end
  end

  // The strobe bit never stores a one; it lives for the single clock after the write.
  // A strobe written while busy is dropped here, so it cannot fire once busy falls.
  always_ff @(posedge CLK_SYS) begin
    if (soft_clear) begin
      mode_reg_select <= RST_MR_SEL;
      mode_reg_write_value <= RST_MR_VALUE;
      mode_reg_write_strobe <= 1'b0;
    end else begin
      mode_reg_write_strobe <= wr_access && PADDR == OFS_MR_CTRL && PWDATA[POS_MR_STROBE] &&
        !MODE_REG_ACCESS_BUSY;
      if (wr_access && PADDR == OFS_MR_CTRL && !MODE_REG_ACCESS_BUSY) begin
        mode_reg_select <= PWDATA[POS_MR_SEL +: 2];
        mode_reg_write_value <= PWDATA[POS_MR_VALUE +: 16];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      PRDATA <= 32'h00000000;
    end else if (rd_access) begin
      PRDATA <= 32'h00000000;
      case (PADDR)
        OFS_PAD_URG: begin
          PRDATA[POS_PAD_DIS] <= pad_powerdown_disable;
          PRDATA[POS_PAD_TIME +: 3] <= pad_powerdown_time;
          PRDATA[POS_HYST +: HYST_W] <= critical_entry_hysteresis;
        end
        OFS_STATE: begin
          PRDATA[POS_OPSTATE +: 2] <= controller_operating_state;
          PRDATA[POS_HPR_FILL +: FILL_W] <= qstat.high_prio_read_queue_fill;
          PRDATA[POS_LPR_FILL +: FILL_W] <= qstat.low_prio_read_queue_fill;
          PRDATA[POS_WR_FILL +: FILL_W] <= qstat.write_queue_fill;
          PRDATA[POS_STALL] <= qstat.controller_stalled;
        end
        OFS_MR_CTRL: begin
          PRDATA[POS_MR_BUSY] <= MODE_REG_ACCESS_BUSY;
          PRDATA[POS_MR_SEL +: 2] <= mode_reg_select;
          PRDATA[POS_MR_VALUE +: 16] <= mode_reg_write_value;
        end
        default: begin
          PRDATA <= 32'h00000000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status capture and pad control.

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      qstat <= '0;
    end else begin
      qstat <= QUEUE_STATUS;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (soft_clear || !INIT_DONE) begin
      controller_operating_state <= OPST_UNINIT;
    end else if (DRAM_SELF_REFRESH) begin
      controller_operating_state <= OPST_SELF_REFRESH;
    end else if (DRAM_POWERDOWN) begin
      controller_operating_state <= OPST_POWERDOWN;
    end else begin
      controller_operating_state <= OPST_NORMAL;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      PAD_POWERDOWN_ENABLE <= 1'b0;
      PAD_POWERDOWN_TIME <= RST_PAD_TIME;
    end else begin
      PAD_POWERDOWN_ENABLE <= !pad_powerdown_disable;
      PAD_POWERDOWN_TIME <= pad_powerdown_time;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Urgency hysteresis: counters saturate so a long request cannot wrap back.

  always_ff @(posedge CLK_SYS) begin
    if (soft_clear) begin
      rd_urgent_cnt <= '0;
      READ_QUEUE_CRITICAL <= 1'b0;
    end else begin
      rd_urgent_cnt <= READ_QUEUE_URGENT_REQUEST ? sat_inc(rd_urgent_cnt) : '0;
      READ_QUEUE_CRITICAL <= READ_QUEUE_URGENT_REQUEST &&
        (sat_inc(rd_urgent_cnt) >= critical_entry_hysteresis);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (soft_clear) begin
      wr_urgent_cnt <= '0;
      WRITE_QUEUE_CRITICAL <= 1'b0;
    end else begin
      wr_urgent_cnt <= WRITE_QUEUE_URGENT_REQUEST ? sat_inc(wr_urgent_cnt) : '0;
      WRITE_QUEUE_CRITICAL <= WRITE_QUEUE_URGENT_REQUEST &&
        (sat_inc(wr_urgent_cnt) >= critical_entry_hysteresis);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode-register access sequencer. A write wins over a read in the same cycle.

  assign accept_write = mode_reg_write_strobe && (mr_state == MR_IDLE);
  assign accept_read = MR_READ_REQ && !mode_reg_write_strobe && (mr_state == MR_IDLE) &&
    !(wr_access && PADDR == OFS_MR_CTRL && PWDATA[POS_MR_STROBE]);
  assign cmd_issued = MR_CMD.valid && DRAM_CMD_IDLE;
  assign MODE_REG_ACCESS_BUSY = (mr_state != MR_IDLE);

  always_comb begin
    next_mr_state = mr_state;
    case (mr_state)
      MR_IDLE: begin
        if (accept_write) begin
          next_mr_state = MR_WRITE;
        end else if (accept_read) begin
          next_mr_state = MR_READ;
        end
      end
      MR_WRITE: begin
        if (cmd_issued) begin
          next_mr_state = MR_IDLE;
        end
      end
      MR_READ: begin
        if (MR_READ_DONE) begin
          next_mr_state = MR_IDLE;
        end
      end
      default: begin
        next_mr_state = MR_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (soft_clear) begin
      mr_state <= MR_IDLE;
    end else begin
      mr_state <= next_mr_state;
    end
  end

  // The command is held until the scheduler reports an idle slot for it.
  always_ff @(posedge CLK_SYS) begin
    if (soft_clear) begin
      MR_CMD <= '0;
    end else if (accept_write) begin
      MR_CMD.valid <= 1'b1;
      MR_CMD.bank <= mode_reg_select;
      MR_CMD.addr <= mode_reg_write_value;
    end else if (cmd_issued) begin
      MR_CMD.valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_busy_rise;
    @(posedge CLK_SYS) disable iff (!RST_B || !SOFT_RST_B)
      (accept_write || accept_read) |=> MODE_REG_ACCESS_BUSY;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise after accept");

  property p_ignore_busy;
    @(posedge CLK_SYS) disable iff (!RST_B || !SOFT_RST_B)
      (MODE_REG_ACCESS_BUSY && wr_access && PADDR == OFS_MR_CTRL) |=>
        !mode_reg_write_strobe && $stable(mode_reg_select) && $stable(mode_reg_write_value);
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("write taken while busy");

  property p_write_done;
    @(posedge CLK_SYS) disable iff (!RST_B || !SOFT_RST_B)
      (mr_state == MR_WRITE && cmd_issued) |=> !MODE_REG_ACCESS_BUSY && !MR_CMD.valid;
  endproperty
  a_write_done: assert property (p_write_done) else $error("busy held after command");

  property p_write_hold;
    @(posedge CLK_SYS) disable iff (!RST_B || !SOFT_RST_B)
      (mr_state == MR_WRITE && !cmd_issued) |=> MODE_REG_ACCESS_BUSY && MR_CMD.valid;
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("write dropped before issue");

  property p_read_done;
    @(posedge CLK_SYS) disable iff (!RST_B || !SOFT_RST_B)
      (mr_state == MR_READ) |=> (MODE_REG_ACCESS_BUSY == !$past(MR_READ_DONE));
  endproperty
  a_read_done: assert property (p_read_done) else $error("read busy wrong");

  property p_cmd_payload;
    @(posedge CLK_SYS) disable iff (!RST_B || !SOFT_RST_B)
      accept_write |=> MR_CMD.valid && MR_CMD.bank == $past(mode_reg_select) &&
        MR_CMD.addr == $past(mode_reg_write_value);
  endproperty
  a_cmd_payload: assert property (p_cmd_payload) else $error("command payload wrong");

  property p_uninit;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (!SOFT_RST_B || !INIT_DONE) |=> controller_operating_state == OPST_UNINIT;
  endproperty
  a_uninit: assert property (p_uninit) else $error("state not uninitialized");

  property p_normal;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (SOFT_RST_B && INIT_DONE && !DRAM_SELF_REFRESH && !DRAM_POWERDOWN) |=>
        controller_operating_state == OPST_NORMAL;
  endproperty
  a_normal: assert property (p_normal) else $error("state not normal");

  property p_critical_wait;
    @(posedge CLK_SYS) disable iff (!RST_B || !SOFT_RST_B)
      (!READ_QUEUE_URGENT_REQUEST ##1 READ_QUEUE_URGENT_REQUEST && critical_entry_hysteresis == 8'h03
        && $stable(critical_entry_hysteresis)) |=> !READ_QUEUE_CRITICAL;
  endproperty
  a_critical_wait: assert property (p_critical_wait) else $error("critical too early");

  property p_pad_enable;
    @(posedge CLK_SYS) disable iff (!RST_B)
      ##1 1'b1 |-> PAD_POWERDOWN_ENABLE == !$past(pad_powerdown_disable);
  endproperty
  a_pad_enable: assert property (p_pad_enable) else $error("pad enable polarity wrong");

  property p_pad_keep;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (!SOFT_RST_B && !(wr_access && PADDR == OFS_PAD_URG)) |=> $stable(pad_powerdown_time);
  endproperty
  a_pad_keep: assert property (p_pad_keep) else $error("pad time lost in soft reset");

  c_mr_write: cover property (@(posedge CLK_SYS) disable iff (!RST_B)
    accept_write ##[1:20] cmd_issued);
  c_mr_read: cover property (@(posedge CLK_SYS) disable iff (!RST_B)
    accept_read ##[1:20] MR_READ_DONE);
  c_critical: cover property (@(posedge CLK_SYS) disable iff (!RST_B)
    $rose(WRITE_QUEUE_CRITICAL));
  c_selfref: cover property (@(posedge CLK_SYS) disable iff (!RST_B)
    controller_operating_state == OPST_SELF_REFRESH);
endmodule
`default_nettype wire

// File: bench/ddr2_mem_model.sv
// Far-side model: scheduler idle slots and capture of issued load-mode commands.
`timescale 1ns/10ps
`default_nettype none
module ddr2_mem_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic hold,
  input wire ddr2_mr_pkg::mr_cmd_t mr_cmd,
  output logic dram_cmd_idle,
  output ddr2_mr_pkg::mr_cmd_t last_cmd,
  output int issued
);
  import ddr2_mr_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Idle slots come at random, so a command may wait; hold withholds every slot.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dram_cmd_idle <= 1'b0;
    end else begin
      dram_cmd_idle <= !hold && ($urandom % 2 == 0);
    end
  end
  // A load-mode command is taken only at an edge where it is valid in an idle slot.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      last_cmd <= '0;
      issued <= 0;
    end else if (mr_cmd.valid && dram_cmd_idle) begin
      last_cmd <= mr_cmd;
      issued <= issued + 1;
    end
  end
endmodule
`default_nettype wire

// File: bench/ddr2_ctrl_status_mode_reg_access_tb.sv
// Self-checking testbench of the control, status and mode-register access block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module ddr2_ctrl_status_mode_reg_access_tb;
  import ddr2_mr_pkg::*;
  logic clk_sys = 1'b0, rst_b, soft_rst_b, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic init_done, dram_pd, dram_sr, rd_urg, wr_urg, rd_crit, wr_crit, pad_en, er;
  logic mr_req, mr_done, cmd_idle, busy, hold;
  logic [2:0] pad_time;
  logic [15:0] v;
  queue_status_t qs;
  mr_cmd_t mr_cmd, last_cmd;
  int issued, failures = 0, compares = 0, n0;
  ddr2_ctrl_status_mode_reg_access dut (.CLK_SYS(clk_sys), .RST_B(rst_b),
    .SOFT_RST_B(soft_rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .INIT_DONE(init_done), .DRAM_POWERDOWN(dram_pd), .DRAM_SELF_REFRESH(dram_sr),
    .QUEUE_STATUS(qs), .READ_QUEUE_URGENT_REQUEST(rd_urg), .WRITE_QUEUE_URGENT_REQUEST(wr_urg),
    .READ_QUEUE_CRITICAL(rd_crit), .WRITE_QUEUE_CRITICAL(wr_crit),
    .PAD_POWERDOWN_ENABLE(pad_en), .PAD_POWERDOWN_TIME(pad_time), .MR_READ_REQ(mr_req),
    .MR_READ_DONE(mr_done), .DRAM_CMD_IDLE(cmd_idle), .MR_CMD(mr_cmd),
    .MODE_REG_ACCESS_BUSY(busy));
  ddr2_mem_model partner (.clk_sys(clk_sys), .rst_b(rst_b), .hold(hold), .mr_cmd(mr_cmd),
    .dram_cmd_idle(cmd_idle), .last_cmd(last_cmd), .issued(issued));
  ////////////////////////////////////////////////////////////////////////////////
  always #10 clk_sys = ~clk_sys;
  task automatic wrap_up();
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // The request stays put until pready is sampled high; read data is taken at that edge.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 200) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK("busy_wait", lvl, busy)
  endtask
  function automatic logic [31:0] exp_status(logic i, logic p, logic s, queue_status_t q);
    logic [1:0] st;
    st = !i ? OPST_UNINIT : s ? OPST_SELF_REFRESH : p ? OPST_POWERDOWN : OPST_NORMAL;
    return {2'h0, st, 4'h0, q.high_prio_read_queue_fill, 4'h0, q.low_prio_read_queue_fill,
      4'h0, q.write_queue_fill, 3'h0, q.controller_stalled};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hE64EE1DB));
    rst_b = 1'b0; soft_rst_b = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; init_done = 1'b0; dram_pd = 1'b0; dram_sr = 1'b0; qs = '0;
    rd_urg = 1'b0; wr_urg = 1'b0; mr_req = 1'b0; mr_done = 1'b0; hold = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    apb(0, OFS_PAD_URG, 0);
    `CHK("pad_reset", 32'h0000_0700, rd)
    `CHK("pad_enable", 1'b1, pad_en)
    `CHK("pad_time", 3'h7, pad_time)
    apb(0, OFS_MR_CTRL, 0);
    `CHK("mr_reset", 32'h0000_0000, rd)
    apb(1, OFS_PAD_URG, 32'h0000_1355);
    repeat (2) @(posedge clk_sys);
    `CHK("pad_disabled", 1'b0, pad_en)
    `CHK("pad_time_set", 3'h3, pad_time)
    soft_rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    soft_rst_b <= 1'b1;
    apb(0, OFS_PAD_URG, 0);
    `CHK("pad_kept", 32'h0000_1300, rd)
    $display("test reset_and_pad done");
    for (int k = 0; k < 10; k++) begin
      @(posedge clk_sys);
      qs <= (k == 0) ? '1 : queue_status_t'($urandom);
      init_done <= (k == 1) ? 1'b0 : ($urandom % 4 != 0);
      dram_pd <= 1'($urandom);
      dram_sr <= 1'($urandom);
      repeat (3) @(posedge clk_sys);
      apb(0, OFS_STATE, 0);
      `CHK("status", exp_status(init_done, dram_pd, dram_sr, qs), rd)
    end
    apb(1, OFS_STATE, 32'hFFFF_FFFF);
    apb(0, 12'h100, 0);
    `CHK("unmapped_err", 1'b1, er)
    `CHK("unmapped_data", 32'h0, rd)
    $display("test status done");
    for (int k = 0; k < 4; k++) begin
      n0 = (k < 2) ? k : (k == 2) ? 3 : 2 + $urandom % 30;
      apb(1, OFS_PAD_URG, {19'h0, 5'h13, n0[7:0]});
      @(posedge clk_sys);
      rd_urg <= 1'b1;
      wr_urg <= 1'b1;
      v = 0;
      do begin
        @(posedge clk_sys);
        v++;
        #1;
      end while (rd_crit !== 1'b1 && v < 300);
      `CHK("crit_cycles", (n0 == 0) ? 16'd1 : n0[15:0], v)
      `CHK("wr_crit", 1'b1, wr_crit)
      @(posedge clk_sys);
      rd_urg <= 1'b0;
      wr_urg <= 1'b0;
      repeat (2) @(posedge clk_sys);
      `CHK("crit_drop", 2'b00, {rd_crit, wr_crit})
    end
    $display("test hysteresis done");
    for (int s = 0; s < 4; s++) begin
      v = 16'($urandom);
      n0 = issued;
      hold <= 1'b1;
      apb(1, OFS_MR_CTRL, {10'h0, s[1:0], 3'h0, 1'b1, v});
      wait_busy(1'b1);
      `CHK("cmd_fields", {1'b1, s[1:0], v}, mr_cmd)
      apb(1, OFS_MR_CTRL, {10'h0, ~s[1:0], 3'h0, 1'b1, ~v});
      apb(0, OFS_MR_CTRL, 0);
      `CHK("mr_ctrl_busy", {1'b1, 9'h0, s[1:0], 4'h0, v}, rd)
      hold <= 1'b0;
      wait_busy(1'b0);
      `CHK("issued", n0 + 1, issued)
      `CHK("issued_cmd", {1'b1, s[1:0], v}, last_cmd)
    end
    $display("test mode_reg_write done");
    hold <= 1'b1;
    @(posedge clk_sys);
    mr_req <= 1'b1;
    @(posedge clk_sys);
    mr_req <= 1'b0;
    #1;
    `CHK("read_busy_rise", 1'b1, busy)
    n0 = issued;
    hold <= 1'b0;
    apb(1, OFS_MR_CTRL, 32'h0001_1234);
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("read_busy_hold", 1'b1, busy)
    `CHK("read_ignored_wr", n0, issued)
    @(posedge clk_sys);
    mr_done <= 1'b1;
    @(posedge clk_sys);
    mr_done <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("read_busy_fall", 1'b0, busy)
    $display("test mode_reg_read done");
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    apb(0, OFS_PAD_URG, 0);
    `CHK("pad_power_on", 32'h0000_0700, rd)
    $display("test power_on_reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
